// >>> common/thermal_pkg.sv
// Purpose: shared constants for the thermal limit alert target
// Assumes: 10 MHz core clock, register pointer selects one byte register
// Notes:   offsets are command byte values on the serial bus
package thermal_pkg;
  // timing
  localparam int CORE_HZ     = 10_000_000;
  localparam int ROUND_MS    = 190;
  localparam int NUM_CH      = 5;
  localparam int SLOT_CYC    = ROUND_MS * (CORE_HZ / 1000) / NUM_CH;
  localparam int TIMEOUT_MS  = 35;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CORE_HZ / 1000);
  localparam logic [1:0] QUEUE_LEN = 2'h3;
  // command byte offsets
  localparam logic [7:0] PTR_RST     = 8'h00;
  localparam logic [7:0] OFS_LOC_ALT = 8'h00;
  localparam logic [7:0] OFS_CSTAT   = 8'h02;
  localparam logic [7:0] OFS_CFG     = 8'h03;
  localparam logic [7:0] OFS_RATE    = 8'h04;
  localparam logic [7:0] OFS_CHEN    = 8'h05;
  localparam logic [7:0] OFS_STAT1   = 8'h07;
  localparam logic [7:0] OFS_STAT2   = 8'h08;
  localparam logic [7:0] OFS_STAT3   = 8'h09;
  localparam logic [7:0] OFS_STAT4   = 8'h0a;
  localparam logic [7:0] OFS_SHOT    = 8'h0f;
  localparam logic [7:0] OFS_HYST    = 8'h48;
  localparam logic [4:0][7:0] OFS_MSB_S = {8'h14, 8'h13, 8'h12, 8'h11, 8'h10};
  localparam logic [4:0][7:0] OFS_LSB_S = {8'h24, 8'h23, 8'h22, 8'h21, 8'h20};
  localparam logic [4:0][7:0] OFS_MSB_U = {8'h1c, 8'h1b, 8'h1a, 8'h19, 8'hff};
  localparam logic [4:0][7:0] OFS_LSB_U = {8'h2c, 8'h2b, 8'h2a, 8'h29, 8'hff};
  localparam logic [2:0][7:0] OFS_MASK  = {8'h0e, 8'h0d, 8'h0c};
  // limits: local, first, first, remote three, remote four, second, second
  localparam logic [6:0][7:0] OFS_LIM = {8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40};
  localparam logic [6:0][7:0] LIM_RST = {8'h55, 8'h55, 8'h55, 8'h55, 8'h6e, 8'h6e, 8'h55};
  // reset values
  localparam logic [7:0] CFG_RST  = 8'h03;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] CHEN_RST = 8'h1f;
  localparam logic [7:0] HYST_RST = 8'h0a;
  localparam logic [7:0] MASK_RST = 8'h00;
  // field positions
  localparam int CFG_STBY_BIT = 6;
  localparam int CFG_R3QE_BIT = 0;
  localparam int CFG_R4QE_BIT = 1;
  localparam int CSTAT_BUSY_BIT = 7;
  // reading reported for a faulty remote diode (-128.000 signed)
  localparam logic [10:0] FAULT_TEMP = 11'h400;
endpackage

// >>> hdl/pin_sync.sv
// Purpose: two-flop synchroniser with edge pulses for a bus pin
// Assumes: pin level is asynchronous to the core clock
// Notes:   first flop feeds only the second
module pin_sync (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  // pin and sampled view
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t sync_reg;
  sync_t sync_next;

  // shift chain; idle bus level is high
  always_comb
  begin
    sync_next = '{s1: i_pin, s2: sync_reg.s1, s3: sync_reg.s2};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      sync_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    else
      sync_reg <= sync_next;
  end

  assign o_level = sync_reg.s2;
  assign o_rise  = sync_reg.s2 & ~sync_reg.s3;
  assign o_fall  = ~sync_reg.s2 & sync_reg.s3;
endmodule

// >>> hdl/channel_compare.sv
// Purpose: one limit comparison with hysteresis and optional fault queue
// Assumes: i_update pulses once per finished conversion of the channel
// Notes:   limits and hysteresis in whole degrees, reading in eighths
module channel_compare (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // channel control
  input  wire logic        i_enable,
  input  wire logic        i_queue_en,
  input  wire logic        i_update,
  // operands
  input  wire logic [10:0] i_temp,
  input  wire logic [7:0]  i_limit,
  input  wire logic [7:0]  i_hyst,
  // result
  output logic             o_over
);
  import thermal_pkg::*;

  typedef struct packed {
    logic       flag;
    logic [1:0] cnt;
  } cmp_t;
  cmp_t cmp_reg;
  cmp_t cmp_next;

  logic signed [12:0] temp_x;
  logic signed [12:0] lim_x;
  logic signed [12:0] rel_x;
  logic               over;
  logic               under;

  // widened so limit minus hysteresis cannot wrap
  assign temp_x = {{2{i_temp[10]}}, i_temp};
  assign lim_x  = {{2{i_limit[7]}}, i_limit, 3'h0};
  assign rel_x  = lim_x - $signed({2'h0, i_hyst, 3'h0});
  assign over   = temp_x > lim_x;
  assign under  = temp_x < rel_x;

  always_comb
  begin
    cmp_next = cmp_reg;
    if (!i_enable)
    begin
      cmp_next = '0;
    end
    else if (i_update)
    begin
      if ((!cmp_reg.flag && over) || (cmp_reg.flag && under))
      begin
        // queue needs three agreeing conversions in a row
        if (!i_queue_en || cmp_reg.cnt == QUEUE_LEN - 2'h1)
        begin
          cmp_next.flag = ~cmp_reg.flag;
          cmp_next.cnt  = 2'h0;
        end
        else
          cmp_next.cnt = cmp_reg.cnt + 2'h1;
      end
      else
        cmp_next.cnt = 2'h0; // a single miss restarts the queue
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      cmp_reg <= '0;
    else
      cmp_reg <= cmp_next;
  end

  assign o_over = cmp_reg.flag;
endmodule

// >>> hdl/thermal_limit_alert_smbus_target.sv
// Purpose: thermal limit compare, alert outputs and serial bus target
// Assumes: front end converts one channel per o_conv_start on this clock
// Notes:   pointer does not auto-increment; repeated reads return one register
// Overview of operation
// - three alert outputs are open-drain, active low, only ever pulled low.
// - enabled local reading compared with its limit, reset 85 degrees, into status.
// - remote one and two each compare against first (110) and second (85) limits.
// - remote three and four compare against one limit, reset 85 degrees.
// - alert one uses first limits, alerts two and three the second limits.
// - an over-limit result drives an alert only when its mask bit is clear.
// - comparison outcomes are readable in status registers two to four.
// - flag sets above limit, clears only below limit minus shared hysteresis or when its channel is disabled.
// - diode fault forces reading to -128 signed or 0 unsigned, sets fault bits.
// - pointer resets to 00, local temperature, and holds until next command byte.
// - a write is address byte, command byte, then exactly one data byte.
// - with pointer already set, host reads using only the address byte.
// - other register: address, command, repeated start, address with read bit.
// - bytes shift out msb first; ack or nack accepted after last byte, nack ends read.
// - a full round with all five channels enabled takes about 190 ms; each disabled channel shortens it by one slot.
// - high byte read freezes matching low byte until that low byte is read.
// - serial machine returns to idle when clock or data stays low over 35 ms.
// - a start condition anywhere abandons the transfer and awaits an address.
// - one-shot write in standby runs one round; data discarded, reads zero.
// - one-shot round converts each enabled channel once, then alerts follow.
// - the command byte after the address loads the 8-bit pointer.
// - remote three and four with queue on need three agreeing conversions.
module thermal_limit_alert_smbus_target #(
  parameter logic [6:0] TARGET_ADDR = 7'h2a, // arbitrary bus address
  parameter int         SLOT_CYCLES = thermal_pkg::SLOT_CYC,
  parameter int         TMO_CYCLES  = thermal_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // serial bus pins
  input  wire logic        i_smb_clk,
  input  wire logic        i_smb_dat,
  output logic             o_smb_dat_oe,
  // alert pins, pulled low while enable is high
  output logic             o_alert_out_one_oe,
  output logic             o_alert_out_two_oe,
  output logic             o_alert_out_three_oe,
  // converter front end
  output logic             o_conv_start,
  output logic [2:0]       o_conv_chan,
  input  wire logic        i_conv_done,
  input  wire logic [10:0] i_conv_temp,
  input  wire logic [1:0]  i_conv_fault
);
  import thermal_pkg::*;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_CMD, BUS_CMD_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RACK, BUS_IGNORE
  } bus_state_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_NEXT, SEQ_WAIT, SEQ_HOLD} seq_state_t;

  typedef struct packed {
    bus_state_t       bus;
    logic [3:0]       bits;
    logic [7:0]       sh;
    logic             rw;
    logic             oe;
    logic [19:0]      tmo;
    logic [7:0]       ptr;
    logic [7:0]       cfg;
    logic [7:0]       rate;
    logic [7:0]       chen;
    logic [7:0]       hyst;
    logic [2:0][7:0]  mask;
    logic [6:0][7:0]  lim;
    logic [4:0][10:0] temp;
    logic [4:0][10:0] snap;
    logic [4:0]       lock;
    logic [3:0][1:0]  fault;
    seq_state_t       seq;
    logic [2:0]       ch;
    logic [19:0]      slot;
    logic             shot;
    logic             conv_start;
    logic [2:0]       conv_ch;
    logic [4:0]       upd;
    logic [2:0]       alert;
  } state_t;

  localparam logic [19:0] SLOT_LAST = 20'(SLOT_CYCLES - 1);
  localparam logic [19:0] TMO_LAST  = 20'(TMO_CYCLES);

  state_t     st_reg;
  state_t     st_next;
  logic       scl;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda;
  logic       sda_rise;
  logic       sda_fall;
  logic [6:0] over;
  logic [4:0] stat_first;
  logic [4:0] stat_second;

  // unsigned view clamps negative readings to zero
  function automatic logic [10:0] to_unsigned(input logic [10:0] t);
    return t[10] ? 11'h000 : t;
  endfunction

  function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] p,
                                          input logic [4:0] s1, input logic [4:0] s2);
    logic [7:0]  rd;
    logic [10:0] low;
    logic [10:0] hi_u;
    logic [10:0] lo_u;
    rd = 8'h00; // one-shot and unmapped read zero
    for (int c = 0; c < 5; c++)
    begin
      low  = s.lock[c] ? s.snap[c] : s.temp[c];
      hi_u = to_unsigned(s.temp[c]);
      lo_u = to_unsigned(low);
      if (p == OFS_MSB_S[c] || (c == 0 && p == OFS_LOC_ALT))
        rd = s.temp[c][10:3];
      if (p == OFS_LSB_S[c])
        rd = {low[2:0], 5'h00};
      if (c > 0 && p == OFS_MSB_U[c])
        rd = hi_u[10:3];
      if (c > 0 && p == OFS_LSB_U[c])
        rd = {lo_u[2:0], 5'h00};
    end
    for (int m = 0; m < 3; m++)
      if (p == OFS_MASK[m])
        rd = s.mask[m];
    for (int l = 0; l < 7; l++)
      if (p == OFS_LIM[l])
        rd = s.lim[l];
    if (p == OFS_CSTAT)
      rd = {s.seq != SEQ_IDLE, 3'h0, |s.fault[3], |s.fault[2], |s.fault[1], |s.fault[0]};
    else if (p == OFS_STAT1)
      rd = {s.fault[3], s.fault[2], s.fault[1], s.fault[0]};
    else if (p == OFS_STAT2)
      rd = {3'h0, s1};
    else if (p == OFS_STAT3 || p == OFS_STAT4)
      rd = {3'h0, s2};
    else if (p == OFS_CFG)
      rd = s.cfg;
    else if (p == OFS_RATE)
      rd = s.rate;
    else if (p == OFS_CHEN)
      rd = s.chen;
    else if (p == OFS_HYST)
      rd = s.hyst;
    return rd;
  endfunction

  // both bus lines sampled through two flops
  pin_sync u_scl_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_pin      (i_smb_clk),
    .o_level    (scl),
    .o_rise     (scl_rise),
    .o_fall     (scl_fall)
  );

  pin_sync u_sda_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_pin      (i_smb_dat),
    .o_level    (sda),
    .o_rise     (sda_rise),
    .o_fall     (sda_fall)
  );

  // seven comparisons: local, ..on first limits, on second
  for (genvar i = 0; i < 7; i++)
  begin : g_cmp
    localparam int CH = (i < 5) ? i : i - 4;
    channel_compare u_cmp (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_enable   (st_reg.chen[CH]),
      .i_queue_en ((CH == 3 && st_reg.cfg[CFG_R3QE_BIT]) ||
                   (CH == 4 && st_reg.cfg[CFG_R4QE_BIT])),
      .i_update   (st_reg.upd[CH]),
      .i_temp     (st_reg.temp[CH]),
      .i_limit    (st_reg.lim[i]),
      .i_hyst     (st_reg.hyst),
      .o_over     (over[i])
    );
  end

  // status layout: bit0 local, bits1..4 remote one..four
  assign stat_first  = over[4:0];
  assign stat_second = {over[4], over[3], over[6], over[5], over[0]};

  always_comb
  begin
    logic       do_load;
    logic       do_wr;
    logic [7:0] rd;
    do_load = 1'b0;
    do_wr   = 1'b0;
    rd      = 8'h00;
    st_next = st_reg;
    st_next.conv_start = 1'b0;
    st_next.upd        = 5'h00;

    // bus timeout counts while either line is low
    if (!scl || !sda)
      st_next.tmo = (st_reg.tmo > TMO_LAST) ? st_reg.tmo : st_reg.tmo + 20'h1;
    else
      st_next.tmo = 20'h0;

    if (st_reg.tmo > TMO_LAST)
    begin
      st_next.bus = BUS_IDLE;
      st_next.oe  = 1'b0;
    end
    else if (sda_fall && scl)
    begin
      st_next.bus  = BUS_ADDR;
      st_next.bits = 4'h0;
      st_next.oe   = 1'b0;
    end
    else if (sda_rise && scl)
    begin
      st_next.bus = BUS_IDLE;
      st_next.oe  = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_reg.bus)
        BUS_ADDR, BUS_CMD, BUS_WDATA:
        begin
          st_next.sh   = {st_reg.sh[6:0], sda};
          st_next.bits = st_reg.bits + 4'h1;
        end
        BUS_RACK:
          if (sda)
            st_next.bus = BUS_IGNORE;
        default:
          st_next.bus = st_reg.bus;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_reg.bus)
        BUS_ADDR:
          if (st_reg.bits == 4'h8)
          begin
            if (st_reg.sh[7:1] == TARGET_ADDR)
            begin
              st_next.rw  = st_reg.sh[0];
              st_next.oe  = 1'b1;
              st_next.bus = BUS_ADDR_ACK;
            end
            else
              st_next.bus = BUS_IGNORE;
          end
        BUS_CMD:
          if (st_reg.bits == 4'h8)
          begin
            st_next.ptr = st_reg.sh;
            st_next.oe  = 1'b1;
            st_next.bus = BUS_CMD_ACK;
          end
        BUS_WDATA:
          if (st_reg.bits == 4'h8)
          begin
            do_wr       = 1'b1;
            st_next.oe  = 1'b1;
            st_next.bus = BUS_WDATA_ACK;
          end
        BUS_ADDR_ACK:
        begin
          st_next.oe   = 1'b0;
          st_next.bits = 4'h0;
          if (st_reg.rw)
            do_load = 1'b1;
          else
            st_next.bus = BUS_CMD;
        end
        BUS_CMD_ACK:
        begin
          st_next.oe   = 1'b0;
          st_next.bits = 4'h0;
          st_next.bus  = BUS_WDATA;
        end
        BUS_WDATA_ACK:
        begin
          st_next.oe  = 1'b0;
          st_next.bus = BUS_IGNORE;
        end
        BUS_RDATA:
          if (st_reg.bits == 4'h8)
          begin
            st_next.oe  = 1'b0;
            st_next.bus = BUS_RACK;
          end
          else
          begin
            st_next.sh   = {st_reg.sh[6:0], 1'b0};
            st_next.oe   = ~st_reg.sh[6];
            st_next.bits = st_reg.bits + 4'h1;
          end
        BUS_RACK:
          do_load = 1'b1; // host acked, send the byte again
        default:
          st_next.bus = st_reg.bus;
      endcase
    end

    // byte load for a read, with low-byte freeze side effects
    if (do_load)
    begin
      rd = read_reg(st_reg, st_reg.ptr, stat_first, stat_second);
      st_next.sh   = rd;
      st_next.oe   = ~rd[7];
      st_next.bits = 4'h1;
      st_next.bus  = BUS_RDATA;
      for (int c = 0; c < 5; c++)
      begin
        if (st_reg.ptr == OFS_MSB_S[c] || (c > 0 && st_reg.ptr == OFS_MSB_U[c]) ||
            (c == 0 && st_reg.ptr == OFS_LOC_ALT))
        begin
          st_next.snap[c] = st_reg.temp[c];
          st_next.lock[c] = 1'b1;
        end
        if (st_reg.ptr == OFS_LSB_S[c] || (c > 0 && st_reg.ptr == OFS_LSB_U[c]))
          st_next.lock[c] = 1'b0;
      end
    end

    // register write decode; read-only offsets fall through untouched
    if (do_wr)
    begin
      if (st_reg.ptr == OFS_CFG)
        st_next.cfg = st_reg.sh;
      else if (st_reg.ptr == OFS_RATE)
        st_next.rate = st_reg.sh;
      else if (st_reg.ptr == OFS_CHEN)
        st_next.chen = {3'h0, st_reg.sh[4:0]};
      else if (st_reg.ptr == OFS_HYST)
        st_next.hyst = st_reg.sh;
      else if (st_reg.ptr == OFS_SHOT)
        st_next.shot = st_reg.cfg[CFG_STBY_BIT];
      for (int m = 0; m < 3; m++)
        if (st_reg.ptr == OFS_MASK[m])
          st_next.mask[m] = st_reg.sh;
      for (int l = 0; l < 7; l++)
        if (st_reg.ptr == OFS_LIM[l])
          st_next.lim[l] = st_reg.sh;
    end

    // conversion sequencer: fixed slot per enabled channel
    case (st_reg.seq)
      SEQ_IDLE:
        if (!st_reg.cfg[CFG_STBY_BIT] || st_reg.shot)
        begin
          // a shot written in this very cycle survives, so set wins over consume
          st_next.shot = do_wr && st_reg.ptr == OFS_SHOT && st_reg.cfg[CFG_STBY_BIT];
          st_next.ch   = 3'h0;
          st_next.seq  = SEQ_NEXT;
        end
      SEQ_NEXT:
        if (st_reg.ch == 3'(NUM_CH))
          st_next.seq = SEQ_IDLE;
        else if (st_reg.chen[st_reg.ch])
        begin
          st_next.conv_start = 1'b1;
          st_next.conv_ch    = st_reg.ch;
          st_next.slot       = 20'h0;
          st_next.seq        = SEQ_WAIT;
        end
        else
          st_next.ch = st_reg.ch + 3'h1;
      SEQ_WAIT:
      begin
        st_next.slot = st_reg.slot + 20'h1;
        if (i_conv_done)
        begin
          st_next.temp[st_reg.ch] = i_conv_temp;
          if (st_reg.ch != 3'h0)
          begin
            st_next.fault[st_reg.ch - 3'h1] = i_conv_fault;
            if (|i_conv_fault)
              st_next.temp[st_reg.ch] = FAULT_TEMP;
          end
          st_next.upd[st_reg.ch] = 1'b1;
          st_next.seq = SEQ_HOLD;
        end
      end
      SEQ_HOLD:
      begin
        st_next.slot = st_reg.slot + 20'h1;
        if (st_reg.slot >= SLOT_LAST)
        begin
          st_next.ch  = st_reg.ch + 3'h1;
          st_next.seq = SEQ_NEXT;
        end
      end
      default:
        st_next.seq = SEQ_IDLE;
    endcase

    // alert pins follow unmasked flags
    st_next.alert[0] = |(stat_first & ~st_reg.mask[0][4:0]);
    st_next.alert[1] = |(stat_second & ~st_reg.mask[1][4:0]);
    st_next.alert[2] = |(stat_second & ~st_reg.mask[2][4:0]);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      st_reg      <= '0;
      st_reg.bus  <= BUS_IDLE;
      st_reg.seq  <= SEQ_IDLE;
      st_reg.ptr  <= PTR_RST;
      st_reg.cfg  <= CFG_RST;
      st_reg.rate <= RATE_RST;
      st_reg.chen <= CHEN_RST;
      st_reg.hyst <= HYST_RST;
      st_reg.mask <= {3{MASK_RST}};
      st_reg.lim  <= LIM_RST;
    end
    else
      st_reg <= st_next;
  end

  // open-drain pins: enable high means pulling the line low
  assign o_smb_dat_oe         = st_reg.oe;
  assign o_alert_out_one_oe   = st_reg.alert[0];
  assign o_alert_out_two_oe   = st_reg.alert[1];
  assign o_alert_out_three_oe = st_reg.alert[2];
  assign o_conv_start         = st_reg.conv_start;
  assign o_conv_chan          = st_reg.conv_ch;
endmodule

// >>> verif/thermal_limit_alert_smbus_target_properties.sv
// Purpose: concurrent checks on the thermal limit alert target ports
// Assumes: bound to the target with the same slot and timeout parameters
// Notes:   counters stand in for waits too long for repetition
module thermal_limit_alert_smbus_target_properties #(
  parameter int SLOT_CYCLES = 50,
  parameter int TMO_CYCLES  = 200
) (
  // clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  // serial bus
  input wire logic       i_smb_clk,
  input wire logic       i_smb_dat,
  input wire logic       o_smb_dat_oe,
  // alerts and converter
  input wire logic       o_alert_out_one_oe,
  input wire logic       o_alert_out_two_oe,
  input wire logic       o_alert_out_three_oe,
  input wire logic       o_conv_start,
  input wire logic [2:0] o_conv_chan
);
  int clk_low;
  int dat_low;
  int gap_cnt;
  // per-line low time; a combined count would trip on toggling clock
  always_ff @(posedge i_core_clk)
  begin
    clk_low <= (i_sys_rst || i_smb_clk) ? 0 : clk_low + 1;
    dat_low <= (i_sys_rst || i_smb_dat) ? 0 : dat_low + 1;
    if (i_sys_rst)
      gap_cnt <= SLOT_CYCLES;
    else if (o_conv_start)
      gap_cnt <= 1;
    else if (gap_cnt < SLOT_CYCLES)
      gap_cnt <= gap_cnt + 1;
  end
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_one_pulse;
    o_conv_start ##1 !o_conv_start;
  endsequence
  sequence s_round_open;
    o_conv_start && (o_conv_chan == 3'h0);
  endsequence
  property p_reset_quiet;
    @(posedge i_core_clk) disable iff (1'b0)
    i_sys_rst |=> !(o_smb_dat_oe || o_alert_out_one_oe || o_alert_out_two_oe
      || o_alert_out_three_oe);
  endproperty
  a_conv_pulse: assert property (o_conv_start |-> s_one_pulse)
    else $error("conversion start longer than one cycle");
  a_chan_hold: assert property (
    o_conv_start |-> (o_conv_chan <= 3'h4) ##1 $stable(o_conv_chan) [*8])
    else $error("conversion channel out of range or not held");
  a_start_spacing: assert property (o_conv_start |-> gap_cnt >= SLOT_CYCLES)
    else $error("conversion starts closer than one slot");
  a_round_open: assert property ($fell(i_sys_rst) |-> ##[0:4] s_round_open)
    else $error("no round started after reset");
  a_bus_timeout: assert property (
    (clk_low > TMO_CYCLES + 8 || dat_low > TMO_CYCLES + 8) |-> !o_smb_dat_oe)
    else $error("data still driven after bus timeout");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs pulled low during reset");
  a_drive_clk_low: assert property (
    $rose(o_smb_dat_oe) |-> !i_smb_clk && !$past(i_smb_clk))
    else $error("data drive changed while bus clock high");
  a_start_release: assert property (
    (i_smb_clk && $fell(i_smb_dat)) |-> !o_smb_dat_oe [*6])
    else $error("data driven right after start condition");
endmodule

bind thermal_limit_alert_smbus_target thermal_limit_alert_smbus_target_properties #(
  .SLOT_CYCLES (SLOT_CYCLES),
  .TMO_CYCLES  (TMO_CYCLES)
) u_props (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_smb_clk(i_smb_clk),
  .i_smb_dat(i_smb_dat), .o_smb_dat_oe(o_smb_dat_oe), .o_conv_start(o_conv_start),
  .o_alert_out_one_oe(o_alert_out_one_oe), .o_alert_out_two_oe(o_alert_out_two_oe),
  .o_alert_out_three_oe(o_alert_out_three_oe), .o_conv_chan(o_conv_chan)
);

// >>> verif/conv_model.sv
// Purpose: converter front end answering each start with a reading
// Assumes: starts are spaced beyond the longest answer delay
// Notes:   data toggles outside the done cycle so stale values show
module conv_model (
  // clock
  input  wire logic       i_core_clk,
  // request
  input  wire logic       i_start,
  input  wire logic [2:0] i_chan,
  // answer
  output logic            o_done,
  output logic [10:0]     o_temp,
  output logic [1:0]      o_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] tmp [5];
  logic [1:0]  flt [5];
  logic [2:0]  ch;
  // delay grows with channel, so prompt and slow answers both occur
  initial
  begin
    o_done = 1'b0;
    o_temp = 11'h555;
    o_fault = 2'h3;
    forever
    begin
      @(posedge i_core_clk);
      if (i_start)
      begin
        ch = i_chan;
        repeat (ch + 3'h1) @(posedge i_core_clk);
        #1;
        o_done = 1'b1;
        o_temp = tmp[ch];
        o_fault = flt[ch];
        @(posedge i_core_clk);
        #1;
        o_done = 1'b0;
        o_temp = ~o_temp;
        o_fault = ~o_fault;
      end
    end
  end
endmodule

// >>> verif/thermal_limit_alert_smbus_target_tb.sv
// Purpose: self-checking bench for the thermal limit alert target
// Assumes: host bus tasks here, converter answers from conv_model
// Notes:   short slot and timeout parameters keep the run brief
module thermal_limit_alert_smbus_target_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import thermal_pkg::*;
  localparam logic [7:0] AW = 8'h54;
  localparam logic [7:0] AR = 8'h55;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl = 1'b1;
  logic        sda = 1'b1;
  logic        oe, cst, cdn, a;
  logic [2:0]  alr, cch;
  logic [1:0]  cfl;
  logic [10:0] ctp;
  logic [7:0]  q;
  int          error_cnt = 0;
  int          compares = 0;
  // open-drain data wire: low if either side pulls
  wire         sda_w = sda & ~oe;
  always #50 clk = ~clk;
  thermal_limit_alert_smbus_target #(.SLOT_CYCLES(50), .TMO_CYCLES(200)) dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_smb_clk(scl), .i_smb_dat(sda_w),
    .o_smb_dat_oe(oe), .o_alert_out_one_oe(alr[2]), .o_alert_out_two_oe(alr[1]),
    .o_alert_out_three_oe(alr[0]), .o_conv_start(cst), .o_conv_chan(cch),
    .i_conv_done(cdn), .i_conv_temp(ctp), .i_conv_fault(cfl));
  conv_model fm (.i_core_clk(clk), .i_start(cst), .i_chan(cch), .o_done(cdn),
    .o_temp(ctp), .o_fault(cfl));
  // inputs move one step after the edge
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus clock: low 4 cycles, high 4, sample at end of high
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tk(2);
    sda = b;
    tk(2);
    scl = 1'b1;
    tk(4);
    r = sda_w;
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(1'b1, k);
  endtask
  // serves as first and repeated start
  task automatic start;
    scl = 1'b0;
    tk(2);
    sda = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda = 1'b0;
    tk(4);
  endtask
  task automatic stop;
    scl = 1'b0;
    tk(2);
    sda = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda = 1'b1;
    tk(4);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    start;
    xb(AW, r, a);
    xb(c, r, a);
    xb(d, r, a);
    chk({7'h0, a}, 8'h00);
    stop;
  endtask
  // host ends every read with a not-acknowledge
  task automatic rd(input logic [7:0] c, input logic set, output logic [7:0] v);
    start;
    if (set)
    begin
      xb(AW, v, a);
      xb(c, v, a);
      start;
    end
    xb(AR, v, a);
    xb(8'hff, v, a);
    stop;
  endtask
  task automatic rc(input logic [7:0] c, input logic [7:0] e);
    rd(c, 1'b1, q);
    chk(q, e);
  endtask
  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #4_000_000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    fm.tmp = '{11'h2b0, 11'h320, 11'h280, 11'h2a8, 11'h000};
    fm.flt = '{default: 2'h0};
    tk(5);
    rst = 1'b0;
    tk(700);
    rd(8'h00, 1'b0, q);
    chk(q, 8'h56);
    rc(OFS_STAT2, 8'h01);
    rc(OFS_STAT3, 8'h03);
    chk({5'h0, alr}, 8'h07);
    $display("test 1 done");
    fm.tmp[0] = 11'h200;
    tk(700);
    chk({5'h0, alr}, 8'h03);
    wr(OFS_MASK[1], 8'h02);
    tk(700);
    chk({5'h0, alr}, 8'h01);
    wr(OFS_MASK[1], 8'h00);
    fm.tmp[1] = 11'h260;
    tk(700);
    rc(OFS_STAT3, 8'h02);
    fm.tmp[1] = 11'h250;
    tk(700);
    rc(OFS_STAT3, 8'h00);
    chk({5'h0, alr}, 8'h00);
    $display("test 2 done");
    fm.flt[3] = 2'h1;
    tk(700);
    rc(OFS_MSB_S[3], 8'h80);
    rc(OFS_MSB_U[3], 8'h00);
    rc(OFS_STAT1, 8'h10);
    fm.flt[3] = 2'h0;
    fm.tmp[4] = 11'h209;
    tk(700);
    rc(OFS_MSB_S[4], 8'h41);
    fm.tmp[4] = 11'h20a;
    tk(700);
    rc(OFS_LSB_S[4], 8'h20);
    rc(OFS_LSB_S[4], 8'h40);
    wr(OFS_STAT2, 8'hff);
    rc(OFS_STAT2, 8'h00);
    $display("test 3 done");
    wr(OFS_CFG, 8'h40);
    tk(700);
    fm.tmp[0] = 11'h2b0;
    tk(700);
    chk({5'h0, alr}, 8'h00);
    wr(OFS_SHOT, 8'h5a);
    tk(700);
    chk({5'h0, alr}, 8'h07);
    rc(OFS_SHOT, 8'h00);
    wr(OFS_CHEN, 8'h1e);
    chk({5'h0, alr}, 8'h00);
    $display("test 4 done");
    // stall mid-read with clock low until the target gives up
    start;
    xb(AR, q, a);
    scl = 1'b0;
    tk(300);
    chk({7'h0, oe}, 8'h00);
    rc(OFS_CFG, 8'h40);
    $display("test 5 done");
    stop_test;
  end
endmodule
